/* rtl/tmcc_pkg.sv */
// Overview of operation
// - Free-running up-counter compared to comparators; match interrupts, clears, drives pin.
// - Three-bit clock select: sys/4, sys, high/16, high/64, sub, external.
// - External clock pin counts on rising or falling edge as selected.
// - Two interrupt sources: comparator P on its match, comparator A on its match or, in capture mode, on a capture edge.
// - Capture input reacts to rising, falling or both edges per two-bit select.
// - Single pulse mode launches its pulse from the external clock pin.
// - Second output pin always carries the inverse of the primary output.
// - Compare mode sets output high, low, or toggles on each match.
// - Edge-aligned PWM on the output pair; duty or period from comparators.
// - Compare low byte write goes only to the shared 8-bit holding buffer; counter writes are ignored.
// - Compare high byte write updates high byte and copies buffer into low byte.
// - High byte read returns high byte and snapshots low byte into buffer.
// - Low byte read returns the holding buffer, not the live low byte.
// - Run-enable rising clears the counter; clearing it stops and holds count.
// - Comparator P matches the top three bits to rp with the low seven zero (all ones when rp is 0); A checks all ten.
package tmcc_pkg;
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE  = 10'h001;
  localparam logic [9:0] CNT_MAX  = 10'h3FF;
  localparam logic [6:0] LOW_ZERO = 7'h00;
  localparam logic [2:0] RP_ZERO  = 3'h0;

  // Register offsets
  localparam logic [2:0] REG_CTRL0  = 3'h0;
  localparam logic [2:0] REG_CTRL1  = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMP_LO = 3'h4;
  localparam logic [2:0] REG_CMP_HI = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam logic [2:0] REG_MASK   = 3'h7;

  // Field positions
  localparam int C0_PAUSE = 7;
  localparam int C0_RUN   = 3;
  localparam int C1_OC    = 3;
  localparam int C1_POL   = 2;
  localparam int C1_DPX   = 1;
  localparam int C1_CCLR  = 0;
  localparam int INT_A    = 0;
  localparam int INT_P    = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] INT_ZERO = 2'h0;
  localparam logic [5:0] HI_PAD   = 6'h00;

  // Prescaler terminal counts
  localparam logic [1:0] SYS4_END = 2'h3;
  localparam logic [5:0] H16_END  = 6'h0F;
  localparam logic [5:0] H64_END  = 6'h3F;

  typedef enum logic [2:0] {
    CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
    CK_SUB0 = 3'h4, CK_SUB1 = 3'h5, CK_EXTR = 3'h6, CK_EXTF = 3'h7
  } tmcc_cksel_t;

  typedef enum logic [1:0] {
    M_CMP = 2'h0, M_CAP = 2'h1, M_PWM = 2'h2, M_SPM = 2'h3
  } tmcc_mode_t;

  typedef enum logic [1:0] {
    OA_NONE = 2'h0, OA_LOW = 2'h1, OA_HIGH = 2'h2, OA_TOG = 2'h3
  } tmcc_act_t;

  typedef enum logic [1:0] {
    CE_RISE = 2'h0, CE_FALL = 2'h1, CE_BOTH = 2'h2, CE_NONE = 2'h3
  } tmcc_cedge_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b01, SP_PULSE = 2'b10
  } tmcc_spm_t;
endpackage : tmcc_pkg

/* rtl/tmcc_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module tmcc_tick_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] sel,
  input  wire logic       high_clk_tick,
  input  wire logic       sub_clk_tick,
  input  wire logic       ext_pin,
  output logic            tick,
  output logic            ext_rise
);
  logic [1:0] sys_div;
  logic [5:0] h_div;
  logic       ext_d;
  logic       ext_fall;

  assign ext_rise = ext_pin & ~ext_d;
  assign ext_fall = ~ext_pin & ext_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= ext_pin;
    end
  end

  // Both dividers free-run so a select change needs no restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div <= 2'h0;
      h_div   <= 6'h00;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (high_clk_tick) begin
        h_div <= h_div + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (tmcc_pkg::tmcc_cksel_t'(sel))
      tmcc_pkg::CK_SYS4: tick = (sys_div == tmcc_pkg::SYS4_END);
      tmcc_pkg::CK_SYS:  tick = 1'b1;
      tmcc_pkg::CK_H16:  tick = high_clk_tick &&
                         (h_div[3:0] == tmcc_pkg::H16_END[3:0]);
      tmcc_pkg::CK_H64:  tick = high_clk_tick &&
                         (h_div == tmcc_pkg::H64_END);
      tmcc_pkg::CK_SUB0: tick = sub_clk_tick;
      tmcc_pkg::CK_SUB1: tick = sub_clk_tick;
      tmcc_pkg::CK_EXTR: tick = ext_rise;
      tmcc_pkg::CK_EXTF: tick = ext_fall;
    endcase
  end
endmodule : tmcc_tick_gen
`default_nettype wire

/* rtl/tmcc_core.sv */
`timescale 1ns/1ns
`default_nettype none
module tmcc_core (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       high_clk_tick,
  input  wire logic       sub_clk_tick,
  input  wire logic       external_clock_pin,
  input  wire logic       capture_input_pin,
  output logic            timer_output_pin,
  output logic            timer_output_inverted_pin,
  output logic            irq_a,
  output logic            irq_p,
  output logic            irq
);
  //////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [1:0] mask;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [9:0] cmp_a;
  logic [9:0] cnt;
  logic [7:0] hold_buf;
  logic       run_d;
  logic       run_rise;
  logic       match_a;
  logic       match_p;
  logic       match_a_d;
  logic       match_p_d;
  logic       ev_a;
  logic       ev_p;
  logic       cap_d;
  logic       cap_hit;
  logic       tick;
  logic       ext_rise;
  logic       count_en;
  logic       clr_hit;
  logic       out_lvl;
  logic       next_out;
  logic       pwm_active;
  tmcc_pkg::tmcc_spm_t spm_state;
  tmcc_pkg::tmcc_mode_t mode;
  tmcc_pkg::tmcc_act_t act;
  logic [2:0] rp;
  logic       run;
  logic       pause;
  logic       wr_c0;
  logic       wr_c1;
  logic       wr_alo;
  logic       wr_ahi;
  logic       rd_dhi;
  logic       rd_ahi;
  logic       rd_stat;

  function automatic logic apply_act(input logic cur,
                                     input tmcc_pkg::tmcc_act_t a);
    unique case (a)
      tmcc_pkg::OA_NONE: apply_act = cur;
      tmcc_pkg::OA_LOW:  apply_act = 1'b0;
      tmcc_pkg::OA_HIGH: apply_act = 1'b1;
      tmcc_pkg::OA_TOG:  apply_act = ~cur;
    endcase
  endfunction : apply_act

  function automatic logic hit(input logic [2:0] a,
                               input logic s,
                               input logic [2:0] ra);
    hit = s && (a == ra);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////
  // Field decode
  assign run   = ctrl0[tmcc_pkg::C0_RUN];
  assign pause = ctrl0[tmcc_pkg::C0_PAUSE];
  assign rp    = ctrl0[2:0];
  assign mode  = tmcc_pkg::tmcc_mode_t'(ctrl1[7:6]);
  assign act   = tmcc_pkg::tmcc_act_t'(ctrl1[5:4]);

  assign wr_c0   = hit(addr, wr, tmcc_pkg::REG_CTRL0);
  assign wr_c1   = hit(addr, wr, tmcc_pkg::REG_CTRL1);
  assign wr_alo  = hit(addr, wr, tmcc_pkg::REG_CMP_LO);
  assign wr_ahi  = hit(addr, wr, tmcc_pkg::REG_CMP_HI);
  assign rd_dhi  = hit(addr, rd, tmcc_pkg::REG_CNT_HI);
  assign rd_ahi  = hit(addr, rd, tmcc_pkg::REG_CMP_HI);
  assign rd_stat = hit(addr, rd, tmcc_pkg::REG_STATUS);

  tmcc_tick_gen u_tick (
    .clk           (clk),
    .rst_n         (rst_n),
    .sel           (ctrl0[6:4]),
    .high_clk_tick (high_clk_tick),
    .sub_clk_tick  (sub_clk_tick),
    .ext_pin       (external_clock_pin),
    .tick          (tick),
    .ext_rise      (ext_rise)
  );

  //////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= tmcc_pkg::CTRL_RST;
      ctrl1 <= tmcc_pkg::CTRL_RST;
      mask  <= tmcc_pkg::INT_ZERO;
    end else begin
      if (wr_c0) begin
        ctrl0 <= wdata;
      end
      if (wr_c1) begin
        ctrl1 <= wdata;
      end
      if (hit(addr, wr, tmcc_pkg::REG_MASK)) begin
        mask <= wdata[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Comparators; quiet until the run edge has cleared a stale count
  assign match_a = run && run_d && (cnt == cmp_a);
  assign match_p = run && run_d && ((rp == tmcc_pkg::RP_ZERO) ?
                   (cnt == tmcc_pkg::CNT_MAX) :
                   (cnt[9:7] == rp &&
                    cnt[6:0] == tmcc_pkg::LOW_ZERO));

  always_comb begin
    unique case (tmcc_pkg::tmcc_cedge_t'(ctrl1[5:4]))
      tmcc_pkg::CE_RISE: cap_hit = capture_input_pin & ~cap_d;
      tmcc_pkg::CE_FALL: cap_hit = ~capture_input_pin & cap_d;
      tmcc_pkg::CE_BOTH: cap_hit = capture_input_pin ^ cap_d;
      tmcc_pkg::CE_NONE: cap_hit = 1'b0;
    endcase
  end

  // Edge of the match level, so a held match fires once
  assign ev_a = (mode == tmcc_pkg::M_CAP) ? (run && cap_hit) :
                (match_a && !match_a_d);
  assign ev_p = match_p && !match_p_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_a_d <= 1'b0;
      match_p_d <= 1'b0;
      cap_d     <= 1'b0;
      run_d     <= 1'b0;
    end else begin
      match_a_d <= match_a;
      match_p_d <= match_p;
      cap_d     <= capture_input_pin;
      run_d     <= run;
    end
  end
  assign run_rise = run && !run_d;

  //////////////////////////////////////////////////////////////////////
  // Counter
  assign clr_hit  = ctrl1[tmcc_pkg::C1_CCLR] ? match_a : match_p;
  assign count_en = run && !pause && tick &&
                    (mode != tmcc_pkg::M_SPM ||
                     spm_state == tmcc_pkg::SP_PULSE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= tmcc_pkg::CNT_ZERO;
    end else if (run_rise) begin
      cnt <= tmcc_pkg::CNT_ZERO;
    end else if (mode == tmcc_pkg::M_SPM &&
                 spm_state == tmcc_pkg::SP_IDLE && run && ext_rise) begin
      cnt <= tmcc_pkg::CNT_ZERO;
    end else if (count_en) begin
      if (clr_hit) begin
        cnt <= tmcc_pkg::CNT_ZERO;
      end else begin
        cnt <= cnt + tmcc_pkg::CNT_ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Single pulse sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spm_state <= tmcc_pkg::SP_IDLE;
    end else begin
      unique case (spm_state)
        tmcc_pkg::SP_IDLE:
          if (mode == tmcc_pkg::M_SPM && run && ext_rise) begin
            spm_state <= tmcc_pkg::SP_PULSE;
          end
        tmcc_pkg::SP_PULSE:
          if (!run || ev_a || mode != tmcc_pkg::M_SPM) begin
            spm_state <= tmcc_pkg::SP_IDLE;
          end
        default: spm_state <= tmcc_pkg::SP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output waveform; pins follow next_out so they come from flops
  assign pwm_active = ctrl1[tmcc_pkg::C1_DPX] ?
                      (cnt[9:7] < rp) : (cnt < cmp_a);

  always_comb begin
    next_out = out_lvl;
    unique case (mode)
      tmcc_pkg::M_CMP: begin
        if (run_rise) begin
          next_out = ctrl1[tmcc_pkg::C1_OC];
        end else if (ev_a) begin
          next_out = apply_act(out_lvl, act);
        end
      end
      tmcc_pkg::M_PWM: begin
        next_out = pwm_active ? ctrl1[tmcc_pkg::C1_OC] :
                   ~ctrl1[tmcc_pkg::C1_OC];
      end
      tmcc_pkg::M_SPM: begin
        next_out = (spm_state == tmcc_pkg::SP_PULSE) ?
                   ctrl1[tmcc_pkg::C1_OC] :
                   ~ctrl1[tmcc_pkg::C1_OC];
      end
      tmcc_pkg::M_CAP: next_out = out_lvl;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl                   <= 1'b0;
      timer_output_pin          <= 1'b0;
      timer_output_inverted_pin <= 1'b1;
    end else begin
      out_lvl          <= next_out;
      timer_output_pin <= next_out ^ ctrl1[tmcc_pkg::C1_POL];
      timer_output_inverted_pin <=
        ~(next_out ^ ctrl1[tmcc_pkg::C1_POL]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Compare A value; a capture loses to a software high-byte write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a <= tmcc_pkg::CNT_ZERO;
    end else if (wr_ahi) begin
      cmp_a <= {wdata[1:0], hold_buf};
    end else if (mode == tmcc_pkg::M_CAP && run && cap_hit) begin
      cmp_a <= cnt;
    end
  end

  // One buffer shared by all pairs; mixing orders corrupts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_buf <= 8'h00;
    end else if (wr_alo) begin
      hold_buf <= wdata;
    end else if (rd_dhi) begin
      hold_buf <= cnt[7:0];
    end else if (rd_ahi) begin
      hold_buf <= cmp_a[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupts; a new event beats the read clear
  assign next_status = (rd_stat ? tmcc_pkg::INT_ZERO : status) |
                       {ev_p, ev_a};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= tmcc_pkg::INT_ZERO;
      irq    <= 1'b0;
      irq_a  <= 1'b0;
      irq_p  <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
      irq_a  <= ev_a;
      irq_p  <= ev_p;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        tmcc_pkg::REG_CTRL0:  rdata <= ctrl0;
        tmcc_pkg::REG_CTRL1:  rdata <= ctrl1;
        tmcc_pkg::REG_CNT_LO: rdata <= hold_buf;
        tmcc_pkg::REG_CNT_HI: rdata <= {tmcc_pkg::HI_PAD, cnt[9:8]};
        tmcc_pkg::REG_CMP_LO: rdata <= hold_buf;
        tmcc_pkg::REG_CMP_HI: rdata <= {tmcc_pkg::HI_PAD, cmp_a[9:8]};
        tmcc_pkg::REG_STATUS: rdata <= {tmcc_pkg::HI_PAD, status};
        tmcc_pkg::REG_MASK:   rdata <= {tmcc_pkg::HI_PAD, mask};
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  run_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    run_rise |=> cnt == tmcc_pkg::CNT_ZERO)
    else $error("counter not cleared on run start");

  stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> $stable(cnt))
    else $error("counter moved while stopped");

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (count_en && !clr_hit && !run_rise && mode == tmcc_pkg::M_CMP)
    |=> cnt == $past(cnt) + tmcc_pkg::CNT_ONE)
    else $error("counter did not advance");

  inv_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_output_inverted_pin == !timer_output_pin)
    else $error("inverted pin not complementary");

  low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_alo && mode != tmcc_pkg::M_CAP)
    |=> hold_buf == $past(wdata) && $stable(cmp_a))
    else $error("low write reached compare value");

  high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ahi |=> cmp_a == {$past(wdata[1:0]), $past(hold_buf)})
    else $error("high write did not latch buffer");

  high_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_dhi |=> hold_buf == $past(cnt[7:0]) &&
    rdata[1:0] == $past(cnt[9:8]))
    else $error("high read snapshot wrong");

  low_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit(addr, rd, tmcc_pkg::REG_CNT_LO)
    |=> rdata == $past(hold_buf))
    else $error("low read not from buffer");

  irq_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_p && match_p) |=> !irq_p)
    else $error("compare P pulse repeated");

  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_a |=> status[tmcc_pkg::INT_A] ##0 irq_a)
    else $error("compare A event lost");
endmodule : tmcc_core
`default_nettype wire

/* verification/tmcc_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module tmcc_pin_model (
  input  wire logic clk,
  input  wire logic rst_n,
  output var logic  high_clk_tick,
  output var logic  sub_clk_tick,
  output var logic  ext_pin,
  output var logic  cap_pin
);
  logic [2:0] div;

  // High clock every 2nd cycle, sub clock every 5th
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div           <= 3'h0;
      high_clk_tick <= 1'b0;
    end else begin
      div           <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      high_clk_tick <= ~high_clk_tick;
    end
  end
  assign sub_clk_tick = (div == 3'h4);

  // Pins idle low; treated as routed to the timer
  initial begin
    ext_pin = 1'b0;
    cap_pin = 1'b0;
  end

  // Slow edges, two cycles high and three low between pulses, so every edge is seen
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (2) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : pulse_ext

  task automatic set_cap(input logic v);
    @(posedge clk);
    cap_pin <= v;
  endtask : set_cap
endmodule : tmcc_pin_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module tb;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       hck;
  logic       sck;
  logic       ext_pin;
  logic       cap_pin;
  logic       out_pin;
  logic       out_n_pin;
  logic       irq_a;
  logic       irq_p;
  logic       irq;
  int         n_fail;
  int         n_compared;
  logic [7:0] d;
  logic [7:0] lo;
  int         n;
  int         k;
  int         j;

  tmcc_core DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .high_clk_tick(hck),
    .sub_clk_tick(sck), .external_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .timer_output_pin(out_pin),
    .timer_output_inverted_pin(out_n_pin), .irq_a(irq_a), .irq_p(irq_p),
    .irq(irq));

  tmcc_pin_model pins (.clk(clk), .rst_n(rst_n), .high_clk_tick(hck),
    .sub_clk_tick(sck), .ext_pin(ext_pin), .cap_pin(cap_pin));

  always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand from the cycle after the strobe until the next read
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Cycles until the next event pulse, bounded
  task automatic wait_ev(input logic p, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((p ? irq_p : irq_a) !== 1'b1 && n < lim);
    if ((p ? irq_p : irq_a) !== 1'b1) begin
      n_fail++;
      $display("ERROR at %0t: event never came", $time);
      report_and_stop;
    end
  endtask : wait_ev

  task automatic count_a(input int c);
    repeat (c) begin
      @(posedge clk);
      #1 if (irq_a === 1'b1) k++;
    end
  endtask : count_a
////////////////////////////////////////////////////////////////////////////
  task automatic t_buffer;
    wr_reg(3'h4, 8'hA5);
    wr_reg(3'h5, 8'h03);
    rd_reg(3'h5);
    chk(d, 8'h03);
    rd_reg(3'h4);
    chk(d, 8'hA5);
    wr_reg(3'h4, 8'h5A);
    rd_reg(3'h4);
    chk(d, 8'h5A);
    rd_reg(3'h5);
    rd_reg(3'h4);
    chk(d, 8'hA5);
  endtask : t_buffer

  task automatic t_counter;
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h0, 8'h18);
    repeat (300) @(posedge clk);
    wr_reg(3'h0, 8'h10);
    rd_reg(3'h3);
    chk(d, 8'h01);
    rd_reg(3'h2);
    lo = d;
    wr_reg(3'h2, 8'hFF);
    wr_reg(3'h3, 8'hFF);
    rd_reg(3'h3);
    chk(d, 8'h01);
    rd_reg(3'h2);
    chk(d, lo);
    wr_reg(3'h0, 8'h18);
    rd_reg(3'h3);
    chk(d, 8'h00);
    rd_reg(3'h2);
    chk(d < 8'h08, 1'b1);
  endtask : t_counter

  // Set low, set high, toggle; the run edge restores the idle level
  task automatic t_output;
    logic [7:0] c1 [3] = '{8'h19, 8'h21, 8'h31};
    logic       ex [3] = '{1'b0, 1'b1, 1'b1};
    wr_reg(3'h4, 8'h02);
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h7, 8'h01);
    for (j = 0; j < 3; j++) begin
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h1, c1[j]);
      wr_reg(3'h0, 8'h18);
      wait_ev(1'b0, 50);
      chk(out_pin, ex[j]);
      chk(out_n_pin, !ex[j]);
    end
    wait_ev(1'b0, 50);
    chk(n, 32'h03);
    chk(out_pin, 1'b0);
    chk(irq, 1'b1);
    wr_reg(3'h0, 8'h10);
    rd_reg(3'h6);
    chk(d, 8'h01);
    rd_reg(3'h6);
    chk(d, 8'h00);
    chk(irq, 1'b0);
  endtask : t_output

  task automatic t_clksel;
    logic [31:0] per [6] = '{32'h0C, 32'h03, 32'h60, 32'h180, 32'h0F,
                             32'h0F};
    wr_reg(3'h7, 8'h00);
    wr_reg(3'h1, 8'h01);
    for (j = 0; j < 6; j++) begin
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h0, {1'b0, j[2:0], 4'h8});
      wait_ev(1'b0, 1000);
      wait_ev(1'b0, 1000);
      chk(n, per[j]);
      chk(irq, 1'b0);
    end
    rd_reg(3'h6);
  endtask : t_clksel

  task automatic t_ext;
    wr_reg(3'h1, 8'h00);
    for (j = 6; j < 8; j++) begin
      wr_reg(3'h0, {1'b0, j[2:0], 4'h0});
      wr_reg(3'h0, {1'b0, j[2:0], 4'h8});
      pins.pulse_ext(5);
      repeat (4) @(posedge clk);
      rd_reg(3'h3);
      chk(d, 8'h00);
      rd_reg(3'h2);
      chk(d, 8'h05);
    end
  endtask : t_ext

  // Counter held still so only the capture pin makes events
  task automatic t_cap;
    logic [31:0] ex [4] = '{32'h1, 32'h1, 32'h2, 32'h0};
    for (j = 0; j < 4; j++) begin
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h1, {2'h1, j[1:0], 4'h0});
      wr_reg(3'h0, 8'h68);
      k = 0;
      pins.set_cap(1'b1);
      count_a(10);
      pins.set_cap(1'b0);
      count_a(10);
      chk(k, ex[j]);
    end
  endtask : t_cap

  task automatic t_period;
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h7, 8'h02);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h0, 8'h19);
    wait_ev(1'b1, 300);
    wait_ev(1'b1, 300);
    chk(n, 32'h81);
    chk(irq, 1'b1);
    wr_reg(3'h0, 8'h10);
    rd_reg(3'h6);
    chk(d[1], 1'b1);
  endtask : t_period

  // Window of two whole periods, so phase does not matter
  task automatic t_pwm;
    logic [7:0]  c1 [2] = '{8'h88, 8'h8A};
    logic [31:0] hi [2] = '{32'h20, 32'h100};
    wr_reg(3'h4, 8'h10);
    wr_reg(3'h5, 8'h00);
    for (j = 0; j < 2; j++) begin
      wr_reg(3'h1, c1[j]);
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h0, 8'h19);
      repeat (10) @(posedge clk);
      k = 0;
      n = 0;
      repeat (258) begin
        @(posedge clk);
        #1 if (out_pin === 1'b1) k++;
        if (out_n_pin === 1'b1) n++;
      end
      chk(k, hi[j]);
      chk(n, 32'h102 - hi[j]);
    end
  endtask : t_pwm

  task automatic t_pulse;
    wr_reg(3'h4, 8'h05);
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h1, 8'hC8);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h0, 8'h18);
    k = 0;
    fork
      pins.pulse_ext(1);
      repeat (40) begin
        @(posedge clk);
        #1 if (out_pin === 1'b1) k++;
      end
    join
    chk(k > 3 && k < 9, 1'b1);
  endtask : t_pulse
////////////////////////////////////////////////////////////////////////////
  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    addr       = 3'h0;
    wdata      = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    n_fail     = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(out_n_pin, !out_pin);
    chk(irq, 1'b0);
    t_buffer();
    t_counter();
    t_output();
    t_clksel();
    t_ext();
    t_cap();
    t_period();
    t_pwm();
    t_pulse();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
